// file: wdt_map.vh
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define WDT_ADDR_W          8
`define WDT_ADDR_PWR        8'h87
`define WDT_ADDR_CTRL       8'h8F
`define WDT_ADDR_CNT_LO     8'hF8
`define WDT_ADDR_CNT_HI     8'hF9

// ----------------------------------------------------------------------
// watchdog_control fields
// ----------------------------------------------------------------------
`define WDT_CTRL_ENABLE     7
`define WDT_CTRL_RESTART    6
`define WDT_CTRL_IDLE_RUN   5
`define WDT_CTRL_PS_HI      2
`define WDT_CTRL_PS_LO      0

// ----------------------------------------------------------------------
// power_control fields
// ----------------------------------------------------------------------
`define WDT_PWR_IDLE        0
`define WDT_PWR_PDOWN       1
`define WDT_PWR_GF0         2
`define WDT_PWR_GF1         3

// ----------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------
`define WDT_DATA_ZERO       8'h00
`define WDT_PS_RST          3'h0
`define WDT_CNT_W           14
`define WDT_CNT_ZERO        14'h0000
`define WDT_CNT_MAX         14'h3FFF
`define WDT_PRE_W           8
`define WDT_PRE_ZERO        8'h00

// ----------------------------------------------------------------------
// Timing: 12 oscillator clocks per machine cycle, as 2 x 6
// ----------------------------------------------------------------------
`define WDT_OSC_NS          25
`define WDT_PHASE_W         3
`define WDT_PHASE_ZERO      3'h0
`define WDT_PHASE_LAST      3'h5
`define WDT_HOLD_W          5
`define WDT_HOLD_ZERO       5'h00
`define WDT_HOLD_CYCLES     5'h18

`endif

// file: wdt_mcycle.v
`timescale 1ns/10ps
`include "wdt_map.vh"

module wdt_mcycle (
  input  wire i_mclk,
  input  wire i_nrst,
  input  wire i_run,
  output reg  o_tick
);

  reg                      half_q;
  reg  [`WDT_PHASE_W-1:0]  phase_q;

  // ----------------------------------------------------------------------
  // Divide by two, then six states per machine cycle
  // ----------------------------------------------------------------------
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      half_q  <= 1'b0;
      phase_q <= `WDT_PHASE_ZERO;
      o_tick  <= 1'b0;
    end else if (i_run) begin
      half_q <= ~half_q;
      o_tick <= half_q && (phase_q == `WDT_PHASE_LAST);
      if (half_q) begin
        if (phase_q == `WDT_PHASE_LAST) begin
          phase_q <= `WDT_PHASE_ZERO;
        end else begin
          phase_q <= phase_q + 1'b1;
        end
      end
    end else begin
      o_tick <= 1'b0;
    end
  end

endmodule // wdt_mcycle

// file: wdt_prescaler.v
`timescale 1ns/10ps
`include "wdt_map.vh"

module wdt_prescaler (
  input  wire       i_mclk,
  input  wire       i_nrst,
  input  wire       i_clear,
  input  wire       i_step,
  input  wire [2:0] i_sel,
  output wire       o_tick
);

  reg  [`WDT_PRE_W-1:0] cnt_q;
  reg  [`WDT_PRE_W-1:0] mask;
  wire [2:0]            tap;

  // Lower half swaps: 010 is /4, 001 is /8; upper half is plain binary
  assign tap = i_sel[2] ? i_sel : {i_sel[2], i_sel[0], i_sel[1]};

  always @* begin
    case (tap)
      3'h0:    mask = 8'h01;
      3'h1:    mask = 8'h03;
      3'h2:    mask = 8'h07;
      3'h3:    mask = 8'h0F;
      3'h4:    mask = 8'h1F;
      3'h5:    mask = 8'h3F;
      3'h6:    mask = 8'h7F;
      default: mask = 8'hFF;
    endcase
  end

  assign o_tick = i_step && ((cnt_q & mask) == mask);

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= `WDT_PRE_ZERO;
    end else if (i_clear) begin
      cnt_q <= `WDT_PRE_ZERO;
    end else if (i_step) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule // wdt_prescaler

// file: wdt_top.v
// Behaviour
// - Prescaler steps only while enabled (and in idle only with idle-run set), tap sets time-out
// - Enabled time-out raises a system reset
// - System reset leaves the watchdog disabled
// - Counts only while enable bit is set
// - Restart clears counter, prescaler, itself at the next machine-cycle boundary
// - Idle counting only when idle-run bit set
// - Prescale select maps to divide 2..256
// - Period is osc x 2^14 x prescale x 12
// - System reset zeroes counter and prescaler
// - Oscillator divided by two internally
// - Power bits request idle and power-down
// - Idle stops processor clock, watchdog keeps running only if idle-run bit set
`timescale 1ns/10ps
`include "wdt_map.vh"

module wdt_top (
  input  wire                   i_mclk,
  input  wire                   i_nrst,
  input  wire [`WDT_ADDR_W-1:0] i_addr,
  input  wire [7:0]             i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  input  wire                   i_wake,
  output reg  [7:0]             o_rdata,
  output reg                    o_sys_reset,
  output reg                    o_timeout,
  output reg                    o_cpu_clk_en,
  output reg                    o_idle,
  output reg                    o_powerdown
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg                      enable_q;
  reg                      enable_d;
  reg                      restart_q;
  reg                      restart_d;
  reg                      idle_run_q;
  reg                      idle_run_d;
  reg  [2:0]               ps_q;
  reg  [2:0]               ps_d;
  reg                      gf0_q;
  reg                      gf0_d;
  reg                      gf1_q;
  reg                      gf1_d;
  reg                      idle_d;
  reg                      pdown_d;
  reg  [`WDT_CNT_W-1:0]    cnt_q;
  reg  [`WDT_CNT_W-1:0]    cnt_d;
  reg  [`WDT_HOLD_W-1:0]   hold_q;
  reg  [`WDT_HOLD_W-1:0]   hold_d;
  reg  [7:0]               rdata_d;
  reg                      timeout_d;

  wire                     wr_ctrl;
  wire                     wr_pwr;
  wire                     wr_cnt_lo;
  wire                     wr_cnt_hi;
  wire                     in_reset;
  wire                     run;
  wire                     mc_tick;
  wire                     pre_clear;
  wire                     pre_step;
  wire                     pre_tick;
  wire                     expire;
  wire [7:0]               ctrl_view;
  wire [7:0]               pwr_view;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  assign wr_ctrl  = i_wr && (i_addr == `WDT_ADDR_CTRL);
  assign wr_pwr   = i_wr && (i_addr == `WDT_ADDR_PWR);
  // Counter halves are writable as a preset
  assign wr_cnt_lo = i_wr && (i_addr == `WDT_ADDR_CNT_LO);
  assign wr_cnt_hi = i_wr && (i_addr == `WDT_ADDR_CNT_HI);
  // Writes during the reset pulse are overridden below, not refused here
  assign in_reset = (hold_q != `WDT_HOLD_ZERO);

  // Power-down stops the oscillator, so the whole chain halts
  assign run = !o_powerdown &&
               enable_q &&
               (!o_idle || idle_run_q);

  // ----------------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------------
  wdt_mcycle u_mcycle (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .i_run  (!o_powerdown),
    .o_tick (mc_tick)
  );

  // Restart takes effect on the next machine-cycle boundary
  assign pre_clear = in_reset || (restart_q && mc_tick);
  assign pre_step  = mc_tick && run && !restart_q;

  wdt_prescaler u_prescaler (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_clear (pre_clear),
    .i_step  (pre_step),
    .i_sel   (ps_q),
    .o_tick  (pre_tick)
  );

  // 2^14 prescaled ticks x 12 clocks each machine cycle
  assign expire = pre_tick && (cnt_q == `WDT_CNT_MAX);

  // ----------------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------------
  // Restart reads back 1 until its boundary passes
  assign ctrl_view = {enable_q, restart_q, idle_run_q, 2'b00, ps_q};
  assign pwr_view  = {4'h0, gf1_q, gf0_q, o_powerdown, o_idle};

  // ----------------------------------------------------------------------
  // Next state: control and power registers
  // ----------------------------------------------------------------------
  always @* begin
    enable_d   = enable_q;
    restart_d  = restart_q;
    idle_run_d = idle_run_q;
    ps_d       = ps_q;
    gf0_d      = gf0_q;
    gf1_d      = gf1_q;
    idle_d     = o_idle;
    pdown_d    = o_powerdown;

    // Restart self-clears at the boundary; a new write below wins
    if (restart_q && mc_tick) begin
      restart_d = 1'b0;
    end

    if (wr_ctrl) begin
      enable_d   = i_wdata[`WDT_CTRL_ENABLE];
      idle_run_d = i_wdata[`WDT_CTRL_IDLE_RUN];
      ps_d       = i_wdata[`WDT_CTRL_PS_HI:`WDT_CTRL_PS_LO];
      // Writing zero leaves a pending restart alone
      if (i_wdata[`WDT_CTRL_RESTART]) begin
        restart_d = 1'b1;
      end
    end

    // Wake from interrupt, but a same-cycle idle request wins
    if (i_wake) begin
      idle_d = 1'b0;
    end
    if (wr_pwr) begin
      gf0_d = i_wdata[`WDT_PWR_GF0];
      gf1_d = i_wdata[`WDT_PWR_GF1];
      if (i_wdata[`WDT_PWR_IDLE]) begin
        idle_d = 1'b1;
      end
      if (i_wdata[`WDT_PWR_PDOWN]) begin
        pdown_d = 1'b1;
      end
    end

    // Internal system reset: same result as the external one
    if (in_reset) begin
      enable_d   = 1'b0;
      restart_d  = 1'b0;
      idle_run_d = 1'b0;
      ps_d       = `WDT_PS_RST;
      gf0_d      = 1'b0;
      gf1_d      = 1'b0;
      idle_d     = 1'b0;
      pdown_d    = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Next state: counter, time-out and reset hold
  // ----------------------------------------------------------------------
  always @* begin
    cnt_d     = cnt_q;
    hold_d    = hold_q;
    timeout_d = 1'b0;

    if (restart_q && mc_tick) begin
      cnt_d = `WDT_CNT_ZERO;
    end else if (pre_tick) begin
      // Past the top the count wraps to zero
      cnt_d = cnt_q + 1'b1;
    end

    // Preset lets long periods be reached without waiting them out
    if (wr_cnt_lo) begin
      cnt_d[7:0] = i_wdata;
    end
    if (wr_cnt_hi) begin
      cnt_d[`WDT_CNT_W-1:8] = i_wdata[`WDT_CNT_W-9:0];
    end

    // Time-out while a reset is already held just wraps
    if (expire) begin
      timeout_d = 1'b1;
      if (!in_reset) begin
        hold_d = `WDT_HOLD_CYCLES;
      end
    end

    // The reset pulse itself holds the count at zero
    if (in_reset) begin
      hold_d = hold_q - 1'b1;
      cnt_d  = `WDT_CNT_ZERO;
    end
  end

  // ----------------------------------------------------------------------
  // Read port: data valid only in the cycle after the strobe
  // ----------------------------------------------------------------------
  always @* begin
    rdata_d = `WDT_DATA_ZERO;
    if (i_rd) begin
      case (i_addr)
        `WDT_ADDR_CTRL:   rdata_d = ctrl_view;
        `WDT_ADDR_PWR:    rdata_d = pwr_view;
        // Halves are not latched, so a carry between two reads can tear
        `WDT_ADDR_CNT_LO: rdata_d = cnt_q[7:0];
        `WDT_ADDR_CNT_HI: rdata_d = {2'b00, cnt_q[`WDT_CNT_W-1:8]};
        default:          rdata_d = `WDT_DATA_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Control and power registers
  // ----------------------------------------------------------------------
  // Reset leaves the watchdog stopped until software enables it
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      enable_q   <= 1'b0;
      restart_q  <= 1'b0;
      idle_run_q <= 1'b0;
      ps_q       <= `WDT_PS_RST;
      gf0_q      <= 1'b0;
      gf1_q      <= 1'b0;
    end else begin
      enable_q   <= enable_d;
      restart_q  <= restart_d;
      idle_run_q <= idle_run_d;
      ps_q       <= ps_d;
      gf0_q      <= gf0_d;
      gf1_q      <= gf1_d;
    end
  end

  // ----------------------------------------------------------------------
  // Counter and reset hold
  // ----------------------------------------------------------------------
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q  <= `WDT_CNT_ZERO;
      hold_q <= `WDT_HOLD_ZERO;
    end else begin
      cnt_q  <= cnt_d;
      hold_q <= hold_d;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= `WDT_DATA_ZERO;
    end else begin
      o_rdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Mode and reset outputs
  // ----------------------------------------------------------------------
  // Pulse is two machine cycles, long enough for the core to see it
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sys_reset  <= 1'b0;
      o_timeout    <= 1'b0;
      o_cpu_clk_en <= 1'b1;
      o_idle       <= 1'b0;
      o_powerdown  <= 1'b0;
    end else begin
      o_sys_reset  <= (hold_d != `WDT_HOLD_ZERO);
      o_timeout    <= timeout_d;
      o_cpu_clk_en <= !idle_d && !pdown_d;
      o_idle       <= idle_d;
      o_powerdown  <= pdown_d;
    end
  end

endmodule // wdt_top

// file: wdt_top_sva.sv
`timescale 1ns/10ps
`include "wdt_map.vh"

module wdt_top_sva (
  input wire                   i_mclk,
  input wire                   i_nrst,
  input wire [`WDT_ADDR_W-1:0] i_addr,
  input wire [7:0]             i_wdata,
  input wire                   i_wr,
  input wire                   i_rd,
  input wire                   i_wake,
  input wire [7:0]             o_rdata,
  input wire                   o_sys_reset,
  input wire                   o_timeout,
  input wire                   o_cpu_clk_en,
  input wire                   o_idle,
  input wire                   o_powerdown
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  reg  [4:0] len_q;
  wire [4:0] len_d  = o_sys_reset ? len_q + 5'h01 : 5'h00;
  // A time-out in the same cycle may override the write
  wire       pwr_wr = i_wr && (i_addr == `WDT_ADDR_PWR) && !o_sys_reset && !o_timeout;
  wire       mapped = (i_addr == `WDT_ADDR_PWR) || (i_addr == `WDT_ADDR_CTRL) ||
                      (i_addr == `WDT_ADDR_CNT_LO) || (i_addr == `WDT_ADDR_CNT_HI);

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst)
      len_q <= 5'h00;
    else
      len_q <= len_d;
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  sequence s_fire;
    o_timeout && (len_q == 5'h00);
  endsequence
  sequence s_pulse;
    o_sys_reset [*8];
  endsequence

  a_fire_reset: assert property (s_fire |-> o_sys_reset ##1 s_pulse)
    else $error("system reset did not follow time-out");
  a_reset_len: assert property ($fell(o_sys_reset) |-> len_q == 5'h18)
    else $error("system reset pulse has wrong length");
  a_reset_cause: assert property ($rose(o_sys_reset) |-> o_timeout)
    else $error("system reset without time-out");
  a_idle_enter: assert property (pwr_wr && i_wdata[`WDT_PWR_IDLE] && !o_powerdown
                                 |=> o_idle && !o_cpu_clk_en)
    else $error("idle not entered");
  a_wake_exit: assert property (o_idle && i_wake && !(pwr_wr && i_wdata[`WDT_PWR_IDLE])
                                |=> !o_idle)
    else $error("wake did not leave idle");
  a_clk_gate: assert property (o_cpu_clk_en != (o_idle || o_powerdown))
    else $error("processor clock enable wrong");
  a_pd_hold: assert property (o_powerdown && !o_sys_reset |=> o_powerdown)
    else $error("power-down left without reset");
  a_rdata_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_rd: assert property (i_rd && !mapped |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_rsvd: assert property (i_rd && i_addr == `WDT_ADDR_CTRL |=> o_rdata[4:3] == 2'b00)
    else $error("reserved control bits not zero");
endmodule // wdt_top_sva

bind wdt_top wdt_top_sva u_sva (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .i_wake(i_wake), .o_rdata(o_rdata), .o_sys_reset(o_sys_reset),
  .o_timeout(o_timeout), .o_cpu_clk_en(o_cpu_clk_en), .o_idle(o_idle),
  .o_powerdown(o_powerdown)
);

// file: wdt_top_tb_top.sv
`timescale 1ns/10ps
`include "wdt_map.vh"

module wdt_top_tb_top;
  reg                   i_mclk, i_nrst, i_wr, i_rd, i_wake;
  reg [`WDT_ADDR_W-1:0] i_addr;
  reg [7:0]             i_wdata;
  wire [7:0]            o_rdata;
  wire                  o_sys_reset, o_timeout, o_cpu_clk_en, o_idle, o_powerdown;
  integer               errors, n_compared, k, n;
  integer               cyc = 0;
  reg [7:0]             rv, c1, c2;
  reg [7:0]             rst_seen = 8'h00;
  reg [7:0]             to_seen = 8'h00;

  wdt_top uut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_wake(i_wake), .o_rdata(o_rdata), .o_sys_reset(o_sys_reset),
    .o_timeout(o_timeout), .o_cpu_clk_en(o_cpu_clk_en), .o_idle(o_idle),
    .o_powerdown(o_powerdown)
  );

  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  // Hang guard, well above the planned 13.4k cycles
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (o_sys_reset) rst_seen <= rst_seen + 8'h01;
    if (o_timeout) to_seen <= to_seen + 8'h01;
    if (cyc == 30000) begin
      errors = errors + 1;
      tally_and_finish;
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge i_mclk);
      i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      #1;
    end
  endtask

  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge i_mclk);
      i_rd <= 1'b1; i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
    end
  endtask

  task chk8(input [7:0] e, input [7:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask

  task chk1(input e, input g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask

  task done(input [63:0] name);
    $display("test %0s done", name);
  endtask

  function integer div_of(input [2:0] ps);
    case (ps)
      3'h0: div_of = 2;
      3'h2: div_of = 4;
      3'h1: div_of = 8;
      3'h3: div_of = 16;
      3'h4: div_of = 32;
      3'h5: div_of = 64;
      3'h6: div_of = 128;
      default: div_of = 256;
    endcase
  endfunction

  task rst_check;
    begin
      chk1(1'b0, o_sys_reset); chk1(1'b0, o_timeout); chk1(1'b1, o_cpu_clk_en);
      rd(`WDT_ADDR_CTRL, rv);   chk8(8'h00, rv);
      rd(`WDT_ADDR_PWR, rv);    chk8(8'h00, rv);
      rd(`WDT_ADDR_CNT_LO, rv); chk8(8'h00, rv);
      rd(`WDT_ADDR_CNT_HI, rv); chk8(8'h00, rv);
      done("reset");
    end
  endtask

  task wake;
    begin
      @(posedge i_mclk) i_wake <= 1'b1;
      @(posedge i_mclk) i_wake <= 1'b0;
      #1;
    end
  endtask

  task tally_and_finish;
    begin
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    i_nrst = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_wake = 1'b0;
    i_addr = 8'h00; i_wdata = 8'h00; errors = 0; n_compared = 0;
    k = $urandom(32'hF31DDF6C);
    repeat (12) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rst_check;
    n = $urandom;
    wr(8'h55, n[7:0]);
    wr(`WDT_ADDR_CTRL, {5'h00, n[2:0]});
    repeat (300) @(posedge i_mclk);
    rd(8'h55, rv);            chk8(8'h00, rv);
    rd(`WDT_ADDR_CTRL, rv);   chk8({5'h00, n[2:0]}, rv);
    rd(`WDT_ADDR_CNT_LO, rv); chk8(8'h00, rv);
    done("disabled");
    for (k = 0; k < 8; k = k + 1) begin
      wr(`WDT_ADDR_CTRL, 8'hC0 | k[7:0]);
      repeat (14) @(posedge i_mclk);
      rd(`WDT_ADDR_CTRL, rv);   chk8(8'h80 | k[7:0], rv);
      rd(`WDT_ADDR_CNT_LO, c1); chk1(1'b1, c1 < 8'h02);
      repeat (24 * div_of(k[2:0]) - 2) @(posedge i_mclk);
      rd(`WDT_ADDR_CNT_LO, c2); chk8(c1 + 8'h02, c2);
    end
    wr(`WDT_ADDR_CTRL, 8'h87);
    rd(`WDT_ADDR_CNT_LO, rv); chk1(1'b1, rv >= c2 && rv != 8'h00);
    done("prescale");
    wr(`WDT_ADDR_CTRL, 8'hC0);
    wr(`WDT_ADDR_PWR, 8'h01);
    chk1(1'b1, o_idle); chk1(1'b0, o_cpu_clk_en);
    // Let the pending restart land before the first sample
    repeat (12) @(posedge i_mclk);
    rd(`WDT_ADDR_CNT_LO, c1);
    repeat (200) @(posedge i_mclk);
    rd(`WDT_ADDR_CNT_LO, c2); chk8(c1, c2);
    wake;
    chk1(1'b0, o_idle); chk1(1'b1, o_cpu_clk_en);
    wr(`WDT_ADDR_CTRL, 8'hE0);
    wr(`WDT_ADDR_PWR, 8'h01);
    repeat (12) @(posedge i_mclk);
    rd(`WDT_ADDR_CNT_LO, c1);
    repeat (70) @(posedge i_mclk);
    rd(`WDT_ADDR_CNT_LO, c2); chk8(c1 + 8'h03, c2);
    wake;
    done("idle");
    wr(`WDT_ADDR_PWR, {4'h0, n[5:4], 2'b10});
    chk1(1'b1, o_powerdown); chk1(1'b0, o_cpu_clk_en);
    rd(`WDT_ADDR_PWR, rv);    chk8({4'h0, n[5:4], 2'b10}, rv);
    rd(`WDT_ADDR_CNT_LO, c1);
    repeat (100) @(posedge i_mclk);
    rd(`WDT_ADDR_CNT_LO, c2); chk8(c1, c2);
    wake;
    chk1(1'b1, o_powerdown);
    done("pdown");
    @(posedge i_mclk) i_nrst <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_nrst <= 1'b1;
    #1;
    chk1(1'b0, o_powerdown);
    rst_check;
    // Preset near the top, restart in time: no reset may follow
    wr(`WDT_ADDR_CTRL, 8'hC0);
    repeat (14) @(posedge i_mclk);
    c1 = rst_seen;
    wr(`WDT_ADDR_CNT_HI, 8'h3F);
    wr(`WDT_ADDR_CNT_LO, 8'hFE);
    wr(`WDT_ADDR_CTRL, 8'hC0);
    repeat (60) @(posedge i_mclk);
    chk8(c1, rst_seen);
    rd(`WDT_ADDR_CNT_HI, rv); chk8(8'h00, rv);
    done("restart");
    // Same preset left alone: one time-out and one full reset pulse
    c1 = rst_seen;
    c2 = to_seen;
    wr(`WDT_ADDR_CNT_HI, 8'h3F);
    wr(`WDT_ADDR_CNT_LO, 8'hFE);
    repeat (90) @(posedge i_mclk);
    rv = rst_seen - c1;
    chk8({3'h0, `WDT_HOLD_CYCLES}, rv);
    rv = to_seen - c2;
    chk8(8'h01, rv);
    rst_check;
    tally_and_finish;
  end
endmodule // wdt_top_tb_top
